//--- shared/srwg_pkg.sv
package srwg_pkg;
// Operation
// RULE1 - resets held through low supply, then timeout
// RULE2 - active-high reset mirrors low reset, open drain
// RULE3 - steady strobe past watchdog period forces reset
// RULE4 - any strobe edge restarts watchdog count
// RULE5 - floating strobe disables the watchdog
// RULE6 - watchdog ignored while supply low
// RULE7 - internal default: 1.6 s watchdog, 200 ms reset
// RULE8 - timebase input low: 100 ms normal period
// RULE9 - external clock: 2048 reset, 4096 first
// RULE10 - capacitor mode scales periods with capacitance
// RULE11 - undriven oscillator select reads high
// RULE12 - supply-low flag follows comparator, no delay
// RULE13 - gated enable low only when passing
// RULE14 - low enable lingers until high or limit
// RULE15 - watchdog reset gates enable like power-down
// RULE16 - gate closed through power-up until release
// RULE17 - pull-up holds gated output high when closed
// RULE18 - battery chosen when below threshold and battery
// RULE19 - backup indication follows selected source
// RULE20 - switchover never alters reset generation
// RULE21 - power-fail flag follows sense, nothing else
// RULE22 - comparator decisions synchronised before use
// RULE23 - periods counted in ticks, first period restarts

	localparam int CLK_NS = 40;
	// internal timebase tick is one millisecond
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
	localparam int CE_HOLD_NS = 12000;
	localparam int CE_HOLD_CYC = CE_HOLD_NS / CLK_NS;
	localparam int HOLD_W = 9;
	localparam int CNT_W = 13;
	localparam int APB_AW = 8;

	localparam logic [CNT_W-1:0] INT_RST_MS = 13'h0c8;
	localparam logic [CNT_W-1:0] INT_WD_LONG_MS = 13'h640;
	localparam logic [CNT_W-1:0] INT_WD_SHORT_MS = 13'h064;
	localparam logic [CNT_W-1:0] EXT_RST_CLKS = 13'h800;
	localparam logic [CNT_W-1:0] EXT_WD_FIRST_CLKS = 13'h1000;
	localparam logic [CNT_W-1:0] EXT_WD_NORM_CLKS = 13'h400;
	// capacitor mode counts are milliseconds per reference capacitance
	localparam logic [CNT_W-1:0] CAP_WD_NORM = 13'h258;
	localparam logic [CNT_W-1:0] CAP_WD_FIRST = 13'h960;
	localparam logic [CNT_W-1:0] CAP_RST = 13'h4b0;
	localparam logic [7:0] CAP_REF_PF = 8'h2f;

	localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
	localparam logic [APB_AW-1:0] STAT_OFS = 8'h04;
	localparam logic [APB_AW-1:0] CNT_OFS = 8'h08;

	localparam int SY_LOW = 0;
	localparam int SY_BATT = 1;
	localparam int SY_PF = 2;
	localparam int SY_WD = 3;
	localparam int SY_FLT = 4;
	localparam int SY_TB = 5;
	localparam int SY_N = 6;

	typedef enum logic [1:0] {
		ST_LOW = 2'h0,
		ST_TMO = 2'h1,
		ST_RUN = 2'h2
	} srwg_st_t;

	typedef enum logic [1:0] {
		M_INT_LONG = 2'h0,
		M_INT_SHORT = 2'h1,
		M_EXT = 2'h2,
		M_CAP = 2'h3
	} srwg_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} srwg_apb_t;

	typedef struct packed {
		logic [22:0] rsvd;
		logic [7:0] cap_pf;
		logic ext_clk;
	} srwg_ctrl_t;

	typedef struct packed {
		logic [21:0] rsvd;
		logic rst_hi_pin;
		logic wd_float;
		logic first;
		logic backup;
		logic gate_en;
		logic reset_n;
		srwg_mode_t mode;
		srwg_st_t st;
	} srwg_stat_t;

	typedef struct packed {
		logic [SY_N-1:0] sy1;
		logic [SY_N-1:0] sy2;
		logic wd_d;
		logic tb_d;
		logic [31:0] presc;
		logic [CNT_W-1:0] cnt;
		srwg_st_t st;
		logic first;
		logic gate_en;
		logic [HOLD_W-1:0] hold;
		logic reset_n;
		logic low_line_n;
		logic pf_n;
		logic backup;
		logic ce_out_n;
		srwg_ctrl_t ctrl;
		logic [31:0] prdata;
		logic pslverr;
	} srwg_state_t;

	localparam srwg_ctrl_t CTRL_RST = '{rsvd: '0, cap_pf: CAP_REF_PF, ext_clk: 1'h0};

	localparam srwg_state_t RST_VAL = '{
		sy1: '0, sy2: '0, wd_d: 1'h0, tb_d: 1'h0, presc: '0, cnt: '0,
		st: ST_LOW, first: 1'h1, gate_en: 1'h0, hold: '0,
		reset_n: 1'h0, low_line_n: 1'h1, pf_n: 1'h1, backup: 1'h0,
		ce_out_n: 1'h1, ctrl: CTRL_RST, prdata: '0, pslverr: 1'h0
	};
endpackage

//--- verilog/srwg_top.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module srwg_top #(
	parameter int TICK_CYC = srwg_pkg::TICK_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire srwg_pkg::srwg_apb_t apb_req,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic supply_low_in,
	input wire logic supply_below_backup_in,
	input wire logic powerfail_sense_low_in,
	input wire logic watchdog_strobe_in,
	input wire logic watchdog_float_in,
	input wire logic timebase_select,
	input wire logic timebase_input,
	input wire logic ce_in_n,
	output logic reset_n,
	output logic reset_hi_o,
	output logic reset_hi_oe,
	input wire logic reset_hi_in,
	output logic low_line_n,
	output logic powerfail_flag_n,
	output logic backup_active,
	output logic ce_out_n,
	output logic ce_pullup_on
);
	srwg_pkg::srwg_state_t s_r;
	srwg_pkg::srwg_state_t s_nxt;
	srwg_pkg::srwg_mode_t mode;
	srwg_pkg::srwg_stat_t stat;
	logic sl;
	logic sb;
	logic pf;
	logic flt;
	logic wd_edge;
	logic tick;
	logic reset_act;
	logic setup;
	logic wr;
	logic [31:0] acc;
	logic [31:0] cap_lim;
	logic [srwg_pkg::CNT_W-1:0] rst_t;
	logic [srwg_pkg::CNT_W-1:0] wd_t;

	always_comb begin
		s_nxt = s_r;
		stat = '0;
		tick = 1'h0;
		rst_t = srwg_pkg::INT_RST_MS;
		wd_t = srwg_pkg::INT_WD_LONG_MS;

		// comparator decisions pass two flops before any use
		s_nxt.sy1 = {timebase_input, watchdog_float_in, watchdog_strobe_in,
			powerfail_sense_low_in, supply_below_backup_in, supply_low_in}; // RULE22
		s_nxt.sy2 = s_r.sy1; // RULE22
		s_nxt.wd_d = s_r.sy2[srwg_pkg::SY_WD];
		s_nxt.tb_d = s_r.sy2[srwg_pkg::SY_TB];
		sl = s_r.sy2[srwg_pkg::SY_LOW];
		sb = s_r.sy2[srwg_pkg::SY_BATT];
		pf = s_r.sy2[srwg_pkg::SY_PF];
		flt = s_r.sy2[srwg_pkg::SY_FLT];
		wd_edge = s_r.sy2[srwg_pkg::SY_WD] ^ s_r.wd_d; // RULE4

		// an open select pin arrives here high through its pull-up
		if (timebase_select) begin // RULE11
			if (s_r.sy2[srwg_pkg::SY_TB]) begin
				mode = srwg_pkg::M_INT_LONG; // RULE7
			end else begin
				mode = srwg_pkg::M_INT_SHORT; // RULE8
			end
		end else if (s_r.ctrl.ext_clk) begin
			mode = srwg_pkg::M_EXT;
		end else begin
			mode = srwg_pkg::M_CAP;
		end

		unique case (mode)
			srwg_pkg::M_INT_LONG: begin
				rst_t = srwg_pkg::INT_RST_MS; // RULE7
				wd_t = srwg_pkg::INT_WD_LONG_MS; // RULE7
			end
			srwg_pkg::M_INT_SHORT: begin
				rst_t = srwg_pkg::INT_RST_MS;
				wd_t = s_r.first ? srwg_pkg::INT_WD_LONG_MS : srwg_pkg::INT_WD_SHORT_MS; // RULE8
			end
			srwg_pkg::M_EXT: begin
				rst_t = srwg_pkg::EXT_RST_CLKS; // RULE9
				wd_t = s_r.first ? srwg_pkg::EXT_WD_FIRST_CLKS : srwg_pkg::EXT_WD_NORM_CLKS; // RULE9
			end
			srwg_pkg::M_CAP: begin
				rst_t = srwg_pkg::CAP_RST; // RULE10
				wd_t = s_r.first ? srwg_pkg::CAP_WD_FIRST : srwg_pkg::CAP_WD_NORM; // RULE10
			end
		endcase

		// capacitor mode: fractional tick of cap_pf/47 ms on average
		cap_lim = 32'(s_r.ctrl.cap_pf) * 32'(TICK_CYC);
		acc = s_r.presc + 32'(srwg_pkg::CAP_REF_PF);
		unique case (mode)
			srwg_pkg::M_EXT: begin
				s_nxt.presc = '0;
				tick = s_r.sy2[srwg_pkg::SY_TB] & ~s_r.tb_d;
			end
			srwg_pkg::M_CAP: begin
				if (acc >= cap_lim) begin
					tick = 1'h1; // RULE10
					s_nxt.presc = acc - cap_lim;
				end else begin
					s_nxt.presc = acc;
				end
			end
			srwg_pkg::M_INT_LONG, srwg_pkg::M_INT_SHORT: begin
				if (s_r.presc >= 32'(TICK_CYC - 1)) begin
					tick = 1'h1;
					s_nxt.presc = '0;
				end else begin
					s_nxt.presc = s_r.presc + 32'h1;
				end
			end
		endcase

		unique case (s_r.st)
			srwg_pkg::ST_LOW: begin
				s_nxt.cnt = '0;
				if (!sl) begin
					s_nxt.st = srwg_pkg::ST_TMO; // RULE1
				end
			end
			srwg_pkg::ST_TMO: begin
				if (tick) begin
					if (s_r.cnt >= rst_t - 13'h001) begin
						s_nxt.st = srwg_pkg::ST_RUN; // RULE1
						s_nxt.cnt = '0;
						s_nxt.first = 1'h1; // RULE23
					end else begin
						s_nxt.cnt = s_r.cnt + 13'h001; // RULE23
					end
				end
			end
			srwg_pkg::ST_RUN: begin
				if (flt) begin
					s_nxt.cnt = '0; // RULE5
				end else if (wd_edge) begin
					s_nxt.cnt = '0; // RULE4
					s_nxt.first = 1'h0;
				end else if (tick) begin
					if (s_r.cnt >= wd_t - 13'h001) begin
						s_nxt.st = srwg_pkg::ST_TMO; // RULE3
						s_nxt.cnt = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + 13'h001; // RULE23
					end
				end
			end
			default: begin
				s_nxt.st = srwg_pkg::ST_LOW;
				s_nxt.cnt = '0;
			end
		endcase
		// a low supply overrides everything and silences the watchdog
		if (sl) begin
			s_nxt.st = srwg_pkg::ST_LOW; // RULE1 RULE6
			s_nxt.cnt = '0;
		end

		// gate: closed in reset, but a cycle already low may finish
		reset_act = s_r.st != srwg_pkg::ST_RUN;
		if (!reset_act) begin
			s_nxt.gate_en = 1'h1;
			s_nxt.hold = '0;
		end else if (s_r.gate_en) begin
			s_nxt.hold = s_r.hold + 9'h001;
			s_nxt.gate_en = ~ce_in_n &
				(s_r.hold != 9'(srwg_pkg::CE_HOLD_CYC - 1)); // RULE14 RULE15
		end else begin
			s_nxt.gate_en = 1'h0; // RULE16
		end
		s_nxt.ce_out_n = s_nxt.gate_en ? ce_in_n : 1'h1; // RULE13 RULE17

		s_nxt.reset_n = s_nxt.st == srwg_pkg::ST_RUN; // RULE1
		s_nxt.low_line_n = ~sl; // RULE12
		s_nxt.pf_n = ~pf; // RULE21
		// switchover decision kept apart from the reset path
		s_nxt.backup = sl & sb; // RULE18 RULE19 RULE20

		stat.rst_hi_pin = reset_hi_in;
		stat.wd_float = flt;
		stat.first = s_r.first;
		stat.backup = s_r.backup;
		stat.gate_en = s_r.gate_en;
		stat.reset_n = s_r.reset_n;
		stat.mode = mode;
		stat.st = s_r.st;

		// read data is staged in the setup phase, so no wait states
		setup = apb_req.psel & ~apb_req.penable;
		wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
		if (setup) begin
			s_nxt.pslverr = 1'h0;
			unique case (apb_req.paddr)
				srwg_pkg::CTRL_OFS: s_nxt.prdata = 32'(s_r.ctrl);
				srwg_pkg::STAT_OFS: s_nxt.prdata = 32'(stat);
				srwg_pkg::CNT_OFS: s_nxt.prdata = 32'(s_r.cnt);
				default: begin
					s_nxt.prdata = '0;
					s_nxt.pslverr = 1'h1;
				end
			endcase
		end
		if (wr && apb_req.paddr == srwg_pkg::CTRL_OFS) begin
			s_nxt.ctrl = srwg_pkg::srwg_ctrl_t'(apb_req.pwdata);
			s_nxt.ctrl.rsvd = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_r <= srwg_pkg::RST_VAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready = 1'h1;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign reset_n = s_r.reset_n;
	// open drain: pulls low only while reset is released
	assign reset_hi_o = 1'h0; // RULE2
	assign reset_hi_oe = s_r.reset_n; // RULE2
	assign low_line_n = s_r.low_line_n;
	assign powerfail_flag_n = s_r.pf_n;
	assign backup_active = s_r.backup;
	assign ce_out_n = s_r.ce_out_n;
	assign ce_pullup_on = ~s_r.gate_en; // RULE17

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	rst_low_hold_a: assert property (sl |=> !reset_n) // RULE1
		else $error("reset released while supply low");
	rst_release_a: assert property ($rose(reset_n) |-> $past(tick) &&
		$past(s_r.cnt) == $past(rst_t) - 13'h001) // RULE1
		else $error("reset released before timeout count");
	hi_inverse_a: assert property (reset_hi_oe == reset_n && !reset_hi_o) // RULE2
		else $error("active-high reset not inverse of low reset");
	wd_fire_a: assert property ((s_r.st == srwg_pkg::ST_RUN && !sl && !flt && !wd_edge && tick &&
		s_r.cnt == wd_t - 13'h001) |=> !reset_n ##1 !reset_n) // RULE3
		else $error("watchdog expiry did not assert reset");
	wd_restart_a: assert property ((s_r.st == srwg_pkg::ST_RUN && wd_edge && !sl) |=>
		s_r.cnt == '0 && reset_n) // RULE4
		else $error("strobe edge did not restart watchdog");
	wd_float_a: assert property ((flt && s_r.st == srwg_pkg::ST_RUN && !sl) |=>
		s_r.cnt == '0 && reset_n) // RULE5
		else $error("floating strobe did not disable watchdog");
	wd_off_low_a: assert property (sl |=> s_r.st == srwg_pkg::ST_LOW && s_r.cnt == '0) // RULE6
		else $error("watchdog active while supply low");
	low_line_a: assert property (low_line_n == !$past(sl)) // RULE12
		else $error("supply-low flag does not follow comparator");
	ce_pass_a: assert property (!ce_out_n |-> !$past(ce_in_n)) // RULE13
		else $error("gated enable low without low input");
	ce_limit_a: assert property ((reset_act && s_r.gate_en &&
		s_r.hold == 9'(srwg_pkg::CE_HOLD_CYC - 1)) |=> !s_r.gate_en && ce_out_n) // RULE14
		else $error("gate still open after hold limit");
	ce_powerup_a: assert property ((!s_r.gate_en && reset_act) |=> !s_r.gate_en) // RULE16
		else $error("gate opened during reset");
	ce_pullup_a: assert property (!s_r.gate_en |-> ce_out_n) // RULE17
		else $error("gated enable not held high while closed");
	backup_sel_a: assert property (backup_active == ($past(sl) && $past(sb))) // RULE18
		else $error("backup indication wrong");
	pf_flag_a: assert property (powerfail_flag_n == !$past(pf)) // RULE21
		else $error("power-fail flag does not follow sense");
	backup_rst_a: assert property (backup_active |-> !reset_n) // RULE20
		else $error("reset released during backup mode");
	first_restart_a: assert property ($rose(reset_n) |-> s_r.first) // RULE23
		else $error("first watchdog period not restarted on release");

	powerup_release_c: cover property ($rose(reset_n));
	wd_fault_c: cover property (s_r.st == srwg_pkg::ST_RUN ##1 s_r.st == srwg_pkg::ST_TMO);
	ce_hold_expire_c: cover property (reset_act && s_r.gate_en &&
		s_r.hold == 9'(srwg_pkg::CE_HOLD_CYC - 1));
	wd_float_c: cover property (flt && s_r.st == srwg_pkg::ST_RUN);
	backup_c: cover property ($rose(backup_active));
endmodule

//--- verif/srwg_host_model.sv
`timescale 1ns/10ps
module srwg_host_model #(
	parameter int HALF = 400
) (
	input wire logic core_clk,
	input wire logic en,
	output logic strobe
);
	int cnt = 0;
	logic strobe_r = 1'b0;
	assign strobe = strobe_r;
	// each level is held far longer than the minimum pulse width
	always @(posedge core_clk) begin
		if (en) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) strobe_r <= ~strobe_r;
		end
	end
endmodule

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	srwg_pkg::srwg_apb_t apb_req = '0;
	logic sup_low = 1'b1;
	logic below_bat = 1'b0;
	logic pf_low = 1'b0;
	logic wd_float = 1'b0;
	logic tb_in = 1'b1;
	logic ce_in_n = 1'b1;
	logic wd_en = 1'b0;
	logic tb_sel = 1'b1;
	logic [1:0] tb_div = 2'h0;
	logic wd_strobe, pready, pslverr, reset_n, rst_hi_o, rst_hi_oe, low_line_n, pf_n, bk, ce_out_n, ce_pu, e, s;
	logic [31:0] prdata, rd;
	int err_count = 0;
	int checks = 0;
	int i;
	always #20 core_clk = ~core_clk;
	// external timebase: two cycles high, two low
	always @(posedge core_clk) tb_div <= tb_div + 2'h1;
	srwg_top #(.TICK_CYC(10)) u_dut (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .supply_low_in(sup_low), .supply_below_backup_in(below_bat),
		.powerfail_sense_low_in(pf_low), .watchdog_strobe_in(wd_strobe), .watchdog_float_in(wd_float),
		.timebase_select(tb_sel), .timebase_input(tb_sel ? tb_in : tb_div[1]), .ce_in_n(ce_in_n), .reset_n(reset_n),
		.reset_hi_o(rst_hi_o), .reset_hi_oe(rst_hi_oe), .reset_hi_in(rst_hi_oe ? rst_hi_o : 1'b1),
		.low_line_n(low_line_n), .powerfail_flag_n(pf_n), .backup_active(bk), .ce_out_n(ce_out_n),
		.ce_pullup_on(ce_pu));
	srwg_host_model u_host (.core_clk(core_clk), .en(wd_en), .strobe(wd_strobe));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wait_rst(input logic v, input int lim);
		for (i = 0; i < lim && reset_n !== v; i++) @(posedge core_clk);
		chk(reset_n, v);
		if (reset_n !== v) test_done();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		e = pslverr;
		apb_req <= '0;
		if (pready !== 1'b1) begin
			chk(pready, 1);
			test_done();
		end
	endtask
	initial begin
		cyc(5);
		rstn <= 1'b1;
		cyc(1);
		chk({reset_n, rst_hi_oe, low_line_n, pf_n, bk, ce_out_n, ce_pu}, 7'h1b);
		apb(0, srwg_pkg::CTRL_OFS, 0);
		chk(rd, 32'h0000005e);
		apb(1, srwg_pkg::CTRL_OFS, 32'hffff0025);
		apb(0, srwg_pkg::CTRL_OFS, 0);
		chk(rd, 32'h00000025);
		apb(1, srwg_pkg::CTRL_OFS, 32'h0000005e);
		apb(1, srwg_pkg::STAT_OFS, '1);
		chk(e, 0);
		apb(0, 8'h0c, 0);
		chk({e, rd}, 33'h100000000);
		apb(0, srwg_pkg::CNT_OFS, 0);
		chk({e, rd}, 33'h000000000);
		chk(low_line_n, 0);
		$display("test registers done");
		ce_in_n <= 1'b0;
		sup_low <= 1'b0;
		cyc(5);
		chk(low_line_n, 1);
		chk(ce_out_n, 1);
		cyc(1900);
		chk({reset_n, ce_out_n, ce_pu}, 3'h3);
		wait_rst(1, 300);
		chk({rst_hi_o, rst_hi_oe}, 2'h1);
		apb(0, srwg_pkg::STAT_OFS, 0);
		chk(rd, 32'h000000b2);
		chk({ce_out_n, ce_pu}, 2'h0);
		ce_in_n <= 1'b1;
		cyc(2);
		chk(ce_out_n, 1);
		ce_in_n <= 1'b0;
		cyc(2);
		chk(ce_out_n, 0);
		$display("test power up done");
		sup_low <= 1'b1;
		cyc(100);
		chk({reset_n, low_line_n, ce_out_n}, 3'h0);
		cyc(220);
		chk({ce_out_n, ce_pu}, 2'h3);
		below_bat <= 1'b1;
		pf_low <= 1'b1;
		cyc(5);
		chk({bk, reset_n, pf_n}, 3'h4);
		sup_low <= 1'b0;
		cyc(5);
		chk(bk, 0);
		$display("test power down done");
		tb_in <= 1'b0;
		wait_rst(1, 2300);
		chk(pf_n, 0);
		wd_en <= 1'b1;
		cyc(1500);
		chk(reset_n, 1);
		s = wd_strobe;
		for (i = 0; i < 1000 && wd_strobe === s; i++) @(posedge core_clk);
		chk(wd_strobe, !s);
		wd_en <= 1'b0;
		cyc(900);
		chk(reset_n, 1);
		wait_rst(0, 250);
		cyc(50);
		chk(ce_out_n, 0);
		ce_in_n <= 1'b1;
		cyc(2);
		chk(ce_out_n, 1);
		ce_in_n <= 1'b0;
		cyc(2);
		chk({ce_out_n, ce_pu}, 2'h3);
		wait_rst(1, 2300);
		cyc(1500);
		chk(reset_n, 1);
		wd_float <= 1'b1;
		cyc(16000);
		chk(reset_n, 1);
		$display("test watchdog done");
		sup_low <= 1'b1;
		tb_sel <= 1'b0;
		apb(1, srwg_pkg::CTRL_OFS, 32'h0000005f);
		apb(0, srwg_pkg::STAT_OFS, 0);
		chk(rd[4:0], 5'h08);
		sup_low <= 1'b0;
		cyc(8000);
		chk(reset_n, 0);
		wait_rst(1, 400);
		sup_low <= 1'b1;
		apb(1, srwg_pkg::CTRL_OFS, 32'h000000bc);
		apb(0, srwg_pkg::STAT_OFS, 0);
		chk(rd[4:0], 5'h0c);
		sup_low <= 1'b0;
		cyc(23700);
		chk(reset_n, 0);
		wait_rst(1, 500);
		$display("test timebase modes done");
		test_done();
	end
endmodule
